/* ppo_group_ctrl.sv */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
module ppo_group_ctrl
  import ppo_pkg::*;
#(
  parameter int GROUPS = PPO_GROUPS,
  parameter int GROUP_W = PPO_GROUP_W
)
(
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [PPO_ADDR_W-1:0] PADDR_IN,
  input wire logic [PPO_DATA_W-1:0] PWDATA_IN,
  output logic [PPO_DATA_W-1:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [3:1] TIMER_MATCH_IN,
  output logic [GROUPS*GROUP_W-1:0] PULSE_OUT,
  output logic [GROUPS*GROUP_W-1:0] PULSE_OE_OUT,
  output logic DMA_REQ_OUT,
  output logic TIMER_MATCH0_OUT
);

  localparam int PINS = GROUPS * GROUP_W;

  function automatic logic addr_is(input logic [PPO_ADDR_W-1:0] a, input logic [PPO_ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  ppo_apb_req_s req;
  logic access;
  logic wr_en;
  logic rd_en;

  logic hit_trig_sel;
  logic hit_next_en;
  logic hit_out_data;
  logic hit_next_data;
  logic hit_period;
  logic hit_count;
  logic hit_status;
  logic hit_start;
  logic hit_any;

  logic [15:0] trig_sel_reg;
  logic [PINS-1:0] next_en_reg;
  logic [PINS-1:0] out_data_reg;
  logic [PINS-1:0] out_data_next;
  logic [PINS-1:0] next_data_reg;
  logic [PPO_CNT_W-1:0] period_reg;
  logic start_reg;
  logic match_flag_reg;
  logic match_flag_next;
  logic [PPO_DATA_W-1:0] rdata_reg;
  logic [PPO_DATA_W-1:0] rdata_next;

  ppo_timer_cfg_s timer_cfg;
  logic [PPO_CNT_W-1:0] count;
  logic match0;
  logic [3:0] match_src;
  logic [GROUPS-1:0] group_trig;
  logic [PINS-1:0] copy_mask;
  logic [PINS-1:0] sw_data;
  logic sw_out_write;

  assign req.paddr = PADDR_IN;
  assign req.pwrite = PWRITE_IN;
  assign req.pwdata = PWDATA_IN;

  // zero-wait slave: the access phase always completes at its first edge
  assign access = PSEL_IN && PENABLE_IN;
  assign wr_en = access && req.pwrite;
  assign rd_en = PSEL_IN && !PENABLE_IN && !req.pwrite;

  assign hit_trig_sel = addr_is(req.paddr, PPO_OFS_TRIG_SEL);
  assign hit_next_en = addr_is(req.paddr, PPO_OFS_NEXT_EN);
  assign hit_out_data = addr_is(req.paddr, PPO_OFS_OUT_DATA);
  assign hit_next_data = addr_is(req.paddr, PPO_OFS_NEXT_DATA);
  assign hit_period = addr_is(req.paddr, PPO_OFS_PERIOD);
  assign hit_count = addr_is(req.paddr, PPO_OFS_COUNT);
  assign hit_status = addr_is(req.paddr, PPO_OFS_STATUS);
  assign hit_start = addr_is(req.paddr, PPO_OFS_TIMER_START);
  assign hit_any = hit_trig_sel | hit_next_en | hit_out_data | hit_next_data | hit_period | hit_count
    | hit_status | hit_start;

  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = access && !hit_any;
  assign PRDATA_OUT = rdata_reg;

  // read data is captured in the setup cycle so it is stable through the access phase
  always_comb
  begin
    rdata_next = rdata_reg;
    if (rd_en)
    begin
      rdata_next = '0;
      if (hit_trig_sel)
      begin
        rdata_next[15:0] = trig_sel_reg;
      end
      if (hit_next_en)
      begin
        rdata_next[PINS-1:0] = next_en_reg;
      end
      if (hit_out_data)
      begin
        rdata_next[PINS-1:0] = out_data_reg;
      end
      if (hit_next_data)
      begin
        rdata_next[PINS-1:0] = next_data_reg;
      end
      if (hit_period)
      begin
        rdata_next[PPO_CNT_W-1:0] = period_reg;
      end
      if (hit_count)
      begin
        rdata_next[PPO_CNT_W-1:0] = count;
      end
      if (hit_status)
      begin
        rdata_next[PPO_MATCH_FLAG_BIT] = match_flag_reg;
      end
      if (hit_start)
      begin
        rdata_next[PPO_START_BIT] = start_reg;
      end
    end
  end

  assign timer_cfg.start = start_reg;
  assign timer_cfg.period = period_reg;

  ppo_timer #(
    .CNT_W(PPO_CNT_W)
  ) u_timer (
    .clk_in(CLK_SYS_IN),
    .reset_n_in(RESET_N_IN),
    .cfg_in(timer_cfg),
    .count_out(count),
    .match_out(match0)
  );

  assign match_src = {TIMER_MATCH_IN, match0};
  assign DMA_REQ_OUT = match0;
  assign TIMER_MATCH0_OUT = match0;

  genvar g;
  generate
    for (g = 0; g < GROUPS; g++)
    begin : g_group
      // each group picks its own compare source, so groups run together or apart
      assign group_trig[g] = match_src[trig_sel_reg[g*PPO_SEL_W +: PPO_SEL_W]];
      assign copy_mask[g*GROUP_W +: GROUP_W] = {GROUP_W{group_trig[g]}} & next_en_reg[g*GROUP_W +: GROUP_W];
    end
  endgenerate

  assign sw_out_write = wr_en && hit_out_data;
  assign sw_data = sw_out_write ? req.pwdata[PINS-1:0] : out_data_reg;
  // a trigger in the same cycle as a software write wins on the enabled bits
  assign out_data_next = (copy_mask & next_data_reg) | (~copy_mask & sw_data);

  // set wins over the write-one-to-clear
  assign match_flag_next = match0 | (match_flag_reg & ~(wr_en && hit_status && req.pwdata[PPO_MATCH_FLAG_BIT]));

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      trig_sel_reg <= PPO_RST_TRIG_SEL;
      next_en_reg <= PPO_RST_NEXT_EN[PINS-1:0];
      next_data_reg <= PPO_RST_NEXT_DATA[PINS-1:0];
      period_reg <= PPO_RST_PERIOD;
      start_reg <= 1'b0;
    end
    else if (wr_en)
    begin
      if (hit_trig_sel)
      begin
        trig_sel_reg <= req.pwdata[15:0];
      end
      if (hit_next_en)
      begin
        next_en_reg <= req.pwdata[PINS-1:0];
      end
      if (hit_next_data)
      begin
        next_data_reg <= req.pwdata[PINS-1:0];
      end
      if (hit_period)
      begin
        period_reg <= req.pwdata[PPO_CNT_W-1:0];
      end
      if (hit_start)
      begin
        start_reg <= req.pwdata[PPO_START_BIT];
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      out_data_reg <= PPO_RST_OUT_DATA[PINS-1:0];
      match_flag_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      out_data_reg <= out_data_next;
      match_flag_reg <= match_flag_next;
      rdata_reg <= rdata_next;
    end
  end

  // disabled pins are released rather than forced low
  assign PULSE_OUT = out_data_reg;
  assign PULSE_OE_OUT = next_en_reg;

endmodule : ppo_group_ctrl

/* ppo_group_ctrl_props.sv */
`timescale 1ns/10ps
module ppo_group_ctrl_props
  import ppo_pkg::*;
#(
  parameter int GROUPS = PPO_GROUPS,
  parameter int GROUP_W = PPO_GROUP_W
)
(
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [PPO_ADDR_W-1:0] PADDR_IN,
  input wire logic [PPO_DATA_W-1:0] PWDATA_IN,
  input wire logic [PPO_DATA_W-1:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [3:1] TIMER_MATCH_IN,
  input wire logic [GROUPS*GROUP_W-1:0] PULSE_OUT,
  input wire logic [GROUPS*GROUP_W-1:0] PULSE_OE_OUT,
  input wire logic DMA_REQ_OUT,
  input wire logic TIMER_MATCH0_OUT
);
  wire acc = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;
  wire wr_out = acc && (PADDR_IN == PPO_OFS_OUT_DATA);
  wire wr_en = acc && (PADDR_IN == PPO_OFS_NEXT_EN);
  wire wr_tim = acc && (PADDR_IN == PPO_OFS_TIMER_START || PADDR_IN == PPO_OFS_PERIOD);
  logic [31:0] nd_reg;
  logic [15:0] per_reg;
  logic [16:0] gap_reg;
  logic run_reg;
  logic ok_reg;
  // shadow of software state, so pin checks do not trust the design's registers
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      nd_reg <= 32'h00000000;
      per_reg <= PPO_RST_PERIOD;
      gap_reg <= 17'h00000;
      run_reg <= 1'b0;
      ok_reg <= 1'b0;
    end
    else
    begin
      if (acc && PADDR_IN == PPO_OFS_NEXT_DATA) nd_reg <= PWDATA_IN;
      if (acc && PADDR_IN == PPO_OFS_PERIOD) per_reg <= PWDATA_IN[15:0];
      if (acc && PADDR_IN == PPO_OFS_TIMER_START) run_reg <= PWDATA_IN[PPO_START_BIT];
      gap_reg <= DMA_REQ_OUT ? 17'h00001 : gap_reg + 17'h00001;
      ok_reg <= wr_tim ? 1'b0 : (DMA_REQ_OUT || ok_reg);
    end
  end
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  chk_dma_single: assert property (DMA_REQ_OUT |=> !DMA_REQ_OUT)
    else $error("dma request longer than one cycle");
  chk_match_pair: assert property (DMA_REQ_OUT == TIMER_MATCH0_OUT)
    else $error("dma request and match differ");
  chk_pin_hold: assert property (!DMA_REQ_OUT && !wr_out &&
    !(|{TIMER_MATCH_IN, $past(TIMER_MATCH_IN), $past(TIMER_MATCH_IN, 2)}) |=> $stable(PULSE_OUT))
    else $error("pins moved without cause");
  chk_enable_hold: assert property (!wr_en |=> $stable(PULSE_OE_OUT))
    else $error("pin enable moved without write");
  chk_copy_next: assert property (DMA_REQ_OUT |=>
    ((PULSE_OUT ^ $past(nd_reg)) & $past(PULSE_OE_OUT) & 32'h0000000F) == 32'h00000000)
    else $error("enabled bits not copied");
  chk_keep_masked: assert property (DMA_REQ_OUT && !wr_out |=>
    ((PULSE_OUT ^ $past(PULSE_OUT)) & ~$past(PULSE_OE_OUT) & 32'h0000000F) == 32'h00000000)
    else $error("disabled bit changed");
  chk_period_gap: assert property (DMA_REQ_OUT && ok_reg |-> gap_reg == {1'b0, per_reg} + 17'h00001)
    else $error("match spacing wrong");
  chk_stop_quiet: assert property (!run_reg && !$past(run_reg) && !$past(run_reg, 2) |-> !DMA_REQ_OUT)
    else $error("match while stopped");
endmodule : ppo_group_ctrl_props
bind ppo_group_ctrl ppo_group_ctrl_props #(.GROUPS(GROUPS), .GROUP_W(GROUP_W)) i_props (.CLK_SYS_IN, .RESET_N_IN,
  .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT,
  .TIMER_MATCH_IN, .PULSE_OUT, .PULSE_OE_OUT, .DMA_REQ_OUT, .TIMER_MATCH0_OUT);

/* ppo_pin_load.sv */
`timescale 1ns/10ps
module ppo_pin_load
  import ppo_pkg::*;
(
  input wire logic [PPO_GROUP_W-1:0] pin_in,
  input wire logic [PPO_GROUP_W-1:0] oe_in,
  output logic [PPO_GROUP_W-1:0] level_out
);
  // undriven pins fall to the pull-down, so a stale level cannot pass
  assign level_out = pin_in & oe_in;
endmodule : ppo_pin_load

/* ppo_pkg.sv */
package ppo_pkg;

  localparam int PPO_ADDR_W = 24;
  localparam int PPO_DATA_W = 32;
  localparam int PPO_GROUPS = 8;
  localparam int PPO_GROUP_W = 4;
  localparam int PPO_SEL_W = 2;
  localparam int PPO_CNT_W = 16;

  localparam logic [PPO_ADDR_W-1:0] PPO_OFS_TRIG_SEL = 24'hFFFF80;
  localparam logic [PPO_ADDR_W-1:0] PPO_OFS_NEXT_EN = 24'hFFFF84;
  localparam logic [PPO_ADDR_W-1:0] PPO_OFS_OUT_DATA = 24'hFFFF88;
  localparam logic [PPO_ADDR_W-1:0] PPO_OFS_NEXT_DATA = 24'hFFFF8C;
  localparam logic [PPO_ADDR_W-1:0] PPO_OFS_PERIOD = 24'hFFFF90;
  localparam logic [PPO_ADDR_W-1:0] PPO_OFS_COUNT = 24'hFFFF94;
  localparam logic [PPO_ADDR_W-1:0] PPO_OFS_STATUS = 24'hFFFF98;
  localparam logic [PPO_ADDR_W-1:0] PPO_OFS_TIMER_START = 24'hFFFFBC;

  localparam int PPO_START_BIT = 0;
  localparam int PPO_MATCH_FLAG_BIT = 0;
  localparam logic [PPO_SEL_W-1:0] PPO_SEL_CH0 = 2'h0;

  localparam logic [31:0] PPO_RST_NEXT_EN = 32'h00000000;
  localparam logic [31:0] PPO_RST_OUT_DATA = 32'h00000000;
  localparam logic [31:0] PPO_RST_NEXT_DATA = 32'h00000000;
  localparam logic [15:0] PPO_RST_TRIG_SEL = 16'h0000;
  localparam logic [15:0] PPO_RST_COUNT = 16'h0000;

  localparam int PPO_CLK_MHZ = 50;
  localparam int PPO_PERIOD_US = 20;
  localparam int PPO_PERIOD_CYCLES = PPO_PERIOD_US * PPO_CLK_MHZ;
  localparam logic [15:0] PPO_RST_PERIOD = 16'(PPO_PERIOD_CYCLES - 1);

  typedef struct packed {
    logic [PPO_ADDR_W-1:0] paddr;
    logic pwrite;
    logic [PPO_DATA_W-1:0] pwdata;
  } ppo_apb_req_s;

  typedef struct packed {
    logic start;
    logic [PPO_CNT_W-1:0] period;
  } ppo_timer_cfg_s;

endpackage : ppo_pkg

/* ppo_timer.sv */
`timescale 1ns/10ps
module ppo_timer
  import ppo_pkg::*;
#(
  parameter int CNT_W = PPO_CNT_W
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire ppo_timer_cfg_s cfg_in,
  output logic [CNT_W-1:0] count_out,
  output logic match_out
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic match_reg;
  logic hit;

  // counter clears on the match so the period is compare value plus one
  assign hit = cfg_in.start && (count_reg == cfg_in.period[CNT_W-1:0]);
  assign count_next = !cfg_in.start ? count_reg : (hit ? '0 : count_reg + 1'b1);

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      count_reg <= '0;
      match_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      match_reg <= hit;
    end
  end

  assign count_out = count_reg;
  assign match_out = match_reg;

endmodule : ppo_timer

/* tb_pulse_pattern_output_group.sv */
`timescale 1ns/10ps
module tb_pulse_pattern_output_group
  import ppo_pkg::*;
;
  logic clk_sys;
  logic reset_n;
  logic psel;
  logic penable;
  ppo_apb_req_s req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:1] match_in;
  logic [31:0] pulse;
  logic [31:0] pulse_oe;
  logic dma_req;
  logic match0;
  logic [3:0] level;
  logic [31:0] rd;
  logic err_seen;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  ppo_group_ctrl i_dut (.CLK_SYS_IN(clk_sys), .RESET_N_IN(reset_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(req.pwrite), .PADDR_IN(req.paddr), .PWDATA_IN(req.pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .TIMER_MATCH_IN(match_in), .PULSE_OUT(pulse), .PULSE_OE_OUT(pulse_oe),
    .DMA_REQ_OUT(dma_req), .TIMER_MATCH0_OUT(match0));
  ppo_pin_load i_load (.pin_in(pulse[3:0]), .oe_in(pulse_oe[3:0]), .level_out(level));
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic wr, input logic [23:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    psel <= 1'b1;
    req <= '{addr, wr, data};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // returns one negedge after the pulse, when the pins have taken the copy
  task wait_dma;
    do @(negedge clk_sys); while (dma_req !== 1'b1);
    @(negedge clk_sys);
  endtask : wait_dma
  task t_regs;
    apb(0, PPO_OFS_NEXT_EN, 32'h0);
    check(rd, PPO_RST_NEXT_EN);
    apb(0, PPO_OFS_PERIOD, 32'h0);
    check(rd, {16'h0000, PPO_RST_PERIOD});
    apb(1, PPO_OFS_COUNT, 32'h00001234);
    apb(0, PPO_OFS_COUNT, 32'h0);
    check(rd, 32'h0);
    apb(0, 24'hFFFF00, 32'h0);
    check({rd[30:0], err_seen}, 32'h00000001);
  endtask : t_regs
  task t_init;
    apb(1, PPO_OFS_NEXT_EN, 32'h0000000F);
    apb(1, PPO_OFS_OUT_DATA, 32'h00000005);
    repeat (20) @(negedge clk_sys);
    check({28'h0, level}, 32'h5);
    check(pulse_oe, 32'h0000000F);
  endtask : t_init
  // the bench plays the dma feeder: one table byte per request, wrapping
  task t_seq;
    apb(1, PPO_OFS_TRIG_SEL, 32'h0);
    apb(1, PPO_OFS_PERIOD, 32'h9);
    apb(1, PPO_OFS_NEXT_DATA, 32'h0);
    apb(1, PPO_OFS_TIMER_START, 32'h1);
    for (int i = 0; i < 32; i++)
    begin
      wait_dma();
      check({28'h0, level}, (32'h11 * (i % 16)) & 32'hF);
      apb(1, PPO_OFS_NEXT_DATA, 32'h11 * ((i + 1) % 16));
    end
  endtask : t_seq
  task t_mask;
    logic [31:0] c0;
    wait_dma();
    apb(1, PPO_OFS_NEXT_EN, 32'h000000F3);
    apb(1, PPO_OFS_NEXT_DATA, 32'h000000A5);
    wait_dma();
    check(pulse[7:0], 32'hA1);
    apb(1, PPO_OFS_TRIG_SEL, 32'h4);
    apb(1, PPO_OFS_NEXT_DATA, 32'h0000005E);
    wait_dma();
    check(pulse[7:0], 32'hA2);
    @(posedge clk_sys);
    match_in <= 3'h1;
    @(posedge clk_sys);
    match_in <= 3'h0;
    repeat (4) @(negedge clk_sys);
    check(pulse[7:0], 32'h52);
    apb(1, PPO_OFS_TIMER_START, 32'h0);
    apb(0, PPO_OFS_COUNT, 32'h0);
    c0 = rd;
    repeat (30) @(negedge clk_sys);
    apb(0, PPO_OFS_COUNT, 32'h0);
    check(rd, c0);
    // matches have set the flag and the stopped timer cannot set it again
    apb(0, PPO_OFS_STATUS, 32'h0);
    check(rd, 32'h00000001);
    apb(1, PPO_OFS_STATUS, 32'h00000001);
    apb(0, PPO_OFS_STATUS, 32'h0);
    check(rd, 32'h00000000);
  endtask : t_mask
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    req = '0;
    match_in = 3'h0;
    reset_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs();
    t_init();
    t_seq();
    t_mask();
    complete_run();
  end
endmodule : tb_pulse_pattern_output_group
